// >>> design/hpt_pin_swap.sv
// Swap of the positive and negative data pins of one transceiver
`timescale 1ns/1ps
`default_nettype none

module hpt_pin_swap (
    // Clock and synchronised reset
    input wire logic mclk,
    input wire logic rst_n,
    // Swap control
    input wire logic swap,
    // Transceiver side
    input wire hpt_pkg::hpt_pair_drv_t xcvr_drv,
    output hpt_pkg::hpt_pair_rcv_t xcvr_rcv,
    // Pin side
    output hpt_pkg::hpt_pair_drv_t pin_drv,
    input wire logic positive_data_pin_in,
    input wire logic negative_data_pin_in
);

    logic [1:0] pin_meta;
    logic [1:0] pin_sync;
    hpt_pkg::hpt_pair_drv_t straight_drv;
    hpt_pkg::hpt_pair_drv_t crossed_drv;
    hpt_pkg::hpt_pair_rcv_t straight_rcv;
    hpt_pkg::hpt_pair_rcv_t crossed_rcv;

    // Pins are outside this clock; two stages before use
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            pin_meta <= 2'h0;
            pin_sync <= 2'h0;
        end else begin
            pin_meta <= {positive_data_pin_in, negative_data_pin_in};
            pin_sync <= pin_meta;
        end
    end

    assign straight_drv = xcvr_drv;
    assign crossed_drv = '{pos_out: xcvr_drv.neg_out, pos_oe_n: xcvr_drv.neg_oe_n,
                           neg_out: xcvr_drv.pos_out, neg_oe_n: xcvr_drv.pos_oe_n};
    assign straight_rcv = '{pos_in: pin_sync[1], neg_in: pin_sync[0]};
    assign crossed_rcv = '{pos_in: pin_sync[0], neg_in: pin_sync[1]};

    // Clear keeps roles, set exchanges them both ways
    assign pin_drv = swap ? crossed_drv : straight_drv;
    assign xcvr_rcv = swap ? crossed_rcv : straight_rcv;

endmodule : hpt_pin_swap
`default_nettype wire

// >>> design/hpt_pkg.sv
// Package for the hub port transceiver tuning registers
package hpt_pkg;

    // Configuration byte addresses
    localparam logic [7:0] ADDR_DOWNSTREAM_DRIVE_BOOST = 8'hf8;
    localparam logic [7:0] ADDR_DATA_PIN_SWAP = 8'hfa;

    // Reset values
    localparam logic [7:0] RST_DOWNSTREAM_DRIVE_BOOST = 8'h00;
    localparam logic [7:0] RST_DATA_PIN_SWAP = 8'h00;

    // Read value for an address this bank does not hold
    localparam logic [7:0] UNMAPPED_READ = 8'h00;

    // Boost field positions (low bit of each two-bit field)
    localparam int BOOST_PORT_ONE_LSB = 0;
    localparam int BOOST_PORT_TWO_LSB = 2;
    localparam int BOOST_PORT_THREE_LSB = 4;
    localparam int BOOST_PORT_FOUR_LSB = 6;
    localparam int BOOST_FIELD_W = 2;

    // Swap bit positions
    localparam int SWAP_UPSTREAM_BIT = 0;
    localparam int SWAP_PORT_ONE_BIT = 1;
    localparam int SWAP_PORT_TWO_BIT = 2;
    localparam int SWAP_PORT_FOUR_BIT = 3;

    // Only the low four swap bits exist; the rest are reserved
    localparam logic [7:0] SWAP_WRITABLE_MASK = 8'h0f;

    // Transceiver slots: upstream, then downstream ports one to four
    localparam int NUM_XCVR = 5;
    localparam int XCVR_UP = 0;
    localparam int XCVR_P1 = 1;
    localparam int XCVR_P2 = 2;
    localparam int XCVR_P3 = 3;
    localparam int XCVR_P4 = 4;

    // Drive strength selection of one transceiver
    typedef enum logic [1:0] {
        HPT_DRIVE_NORMAL,
        HPT_DRIVE_LOW_BOOST,
        HPT_DRIVE_MEDIUM_BOOST,
        HPT_DRIVE_HIGH_BOOST
    } hpt_drive_t;

    // Drive levels of the four downstream transceivers
    typedef struct packed {
        hpt_drive_t port_four_drive_level;
        hpt_drive_t port_three_drive_level;
        hpt_drive_t port_two_drive_level;
        hpt_drive_t port_one_drive_level;
    } hpt_boost_t;

    // One differential pair as seen by drive logic or by the pins
    typedef struct packed {
        logic pos_out;
        logic pos_oe_n;
        logic neg_out;
        logic neg_oe_n;
    } hpt_pair_drv_t;

    // Received levels of one differential pair
    typedef struct packed {
        logic pos_in;
        logic neg_in;
    } hpt_pair_rcv_t;

endpackage : hpt_pkg

// >>> design/hpt_tuning_regs.sv
// Drive boost and data pin swap configuration registers of the hub
`timescale 1ns/1ps
`default_nettype none

module hpt_tuning_regs (
    // Clock and reset
    input wire logic mclk,
    input wire logic nrst,
    // Configuration byte port from the loader
    input wire logic [7:0] cfg_addr,
    input wire logic [7:0] cfg_wdata,
    input wire logic cfg_wr,
    input wire logic cfg_rd,
    output logic [7:0] cfg_rdata,
    output logic cfg_rvalid,
    // Drive levels to the downstream transceivers
    output hpt_pkg::hpt_boost_t drive_boost,
    // Swap state per transceiver slot
    output logic [hpt_pkg::NUM_XCVR-1:0] swap_active,
    // Transceiver side of each slot
    input wire hpt_pkg::hpt_pair_drv_t [hpt_pkg::NUM_XCVR-1:0] xcvr_drv,
    output hpt_pkg::hpt_pair_rcv_t [hpt_pkg::NUM_XCVR-1:0] xcvr_rcv,
    // Pin side of each slot
    output logic [hpt_pkg::NUM_XCVR-1:0] positive_data_pin_out,
    output logic [hpt_pkg::NUM_XCVR-1:0] positive_data_pin_oe_n,
    input wire logic [hpt_pkg::NUM_XCVR-1:0] positive_data_pin_in,
    output logic [hpt_pkg::NUM_XCVR-1:0] negative_data_pin_out,
    output logic [hpt_pkg::NUM_XCVR-1:0] negative_data_pin_oe_n,
    input wire logic [hpt_pkg::NUM_XCVR-1:0] negative_data_pin_in
);

    // Two-bit field of a byte, used for every boost slice
    function automatic hpt_pkg::hpt_drive_t boost_field(input logic [7:0] value,
                                                       input int lsb);
        logic [hpt_pkg::BOOST_FIELD_W-1:0] bits;
        bits = value[lsb +: hpt_pkg::BOOST_FIELD_W];
        return hpt_pkg::hpt_drive_t'(bits);
    endfunction : boost_field

    // Reset synchroniser
    logic rst_meta_n;
    logic rst_n;

    // Register storage
    logic [7:0] downstream_drive_boost;
    logic [7:0] data_pin_swap;
    logic [7:0] next_downstream_drive_boost;
    logic [7:0] next_data_pin_swap;

    // Decode
    wire hit_boost;
    wire hit_swap;
    wire wr_boost;
    wire wr_swap;
    wire [7:0] read_mux;

    // Derived controls
    hpt_pkg::hpt_boost_t next_drive_boost;
    logic [hpt_pkg::NUM_XCVR-1:0] next_swap_active;
    hpt_pkg::hpt_pair_drv_t [hpt_pkg::NUM_XCVR-1:0] pin_drv;

    // Reset release through two stages; assertion stays asynchronous
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            rst_meta_n <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_meta_n <= 1'b1;
            rst_n <= rst_meta_n;
        end
    end

    // Address decode
    assign hit_boost = (cfg_addr == hpt_pkg::ADDR_DOWNSTREAM_DRIVE_BOOST);
    assign hit_swap = (cfg_addr == hpt_pkg::ADDR_DATA_PIN_SWAP);
    assign wr_boost = cfg_wr && hit_boost;
    assign wr_swap = cfg_wr && hit_swap;

    // Whole byte stored; every boost code is legal
    assign next_downstream_drive_boost = wr_boost ? cfg_wdata : downstream_drive_boost;

    // Reserved swap bits are forced to zero on store
    assign next_data_pin_swap = wr_swap ? (cfg_wdata & hpt_pkg::SWAP_WRITABLE_MASK)
                                        : data_pin_swap;

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            downstream_drive_boost <= hpt_pkg::RST_DOWNSTREAM_DRIVE_BOOST;
            data_pin_swap <= hpt_pkg::RST_DATA_PIN_SWAP;
        end else begin
            downstream_drive_boost <= next_downstream_drive_boost;
            data_pin_swap <= next_data_pin_swap;
        end
    end

    // Read back; a read in the cycle of a write sees the old value
    assign read_mux = hit_boost ? downstream_drive_boost
                    : hit_swap ? data_pin_swap
                    : hpt_pkg::UNMAPPED_READ;

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            cfg_rdata <= hpt_pkg::UNMAPPED_READ;
            cfg_rvalid <= 1'b0;
        end else begin
            cfg_rdata <= cfg_rd ? read_mux : cfg_rdata;
            cfg_rvalid <= cfg_rd;
        end
    end

    // Boost slices per downstream port
    assign next_drive_boost.port_four_drive_level =
        boost_field(downstream_drive_boost, hpt_pkg::BOOST_PORT_FOUR_LSB);
    assign next_drive_boost.port_three_drive_level =
        boost_field(downstream_drive_boost, hpt_pkg::BOOST_PORT_THREE_LSB);
    assign next_drive_boost.port_two_drive_level =
        boost_field(downstream_drive_boost, hpt_pkg::BOOST_PORT_TWO_LSB);
    assign next_drive_boost.port_one_drive_level =
        boost_field(downstream_drive_boost, hpt_pkg::BOOST_PORT_ONE_LSB);

    // Swap bit per slot; port three has no swap bit and stays straight
    assign next_swap_active[hpt_pkg::XCVR_UP] =
        data_pin_swap[hpt_pkg::SWAP_UPSTREAM_BIT];
    assign next_swap_active[hpt_pkg::XCVR_P1] =
        data_pin_swap[hpt_pkg::SWAP_PORT_ONE_BIT];
    assign next_swap_active[hpt_pkg::XCVR_P2] =
        data_pin_swap[hpt_pkg::SWAP_PORT_TWO_BIT];
    assign next_swap_active[hpt_pkg::XCVR_P3] = 1'b0;
    assign next_swap_active[hpt_pkg::XCVR_P4] =
        data_pin_swap[hpt_pkg::SWAP_PORT_FOUR_BIT];

    // Controls leave through flops so the analogue side sees clean levels
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            drive_boost <= hpt_pkg::hpt_boost_t'(hpt_pkg::RST_DOWNSTREAM_DRIVE_BOOST);
            swap_active <= '0;
        end else begin
            drive_boost <= next_drive_boost;
            swap_active <= next_swap_active;
        end
    end

    // One pin swap per transceiver slot
    genvar g;
    generate
        for (g = 0; g < hpt_pkg::NUM_XCVR; g++) begin : g_slot
            hpt_pin_swap u_swap (
                .mclk(mclk),
                .rst_n(rst_n),
                .swap(swap_active[g]),
                .xcvr_drv(xcvr_drv[g]),
                .xcvr_rcv(xcvr_rcv[g]),
                .pin_drv(pin_drv[g]),
                .positive_data_pin_in(positive_data_pin_in[g]),
                .negative_data_pin_in(negative_data_pin_in[g])
            );
            assign positive_data_pin_out[g] = pin_drv[g].pos_out;
            assign positive_data_pin_oe_n[g] = pin_drv[g].pos_oe_n;
            assign negative_data_pin_out[g] = pin_drv[g].neg_out;
            assign negative_data_pin_oe_n[g] = pin_drv[g].neg_oe_n;
        end
    endgenerate

endmodule : hpt_tuning_regs
`default_nettype wire

// >>> verif/hpt_cfg_loader.sv
// Behavioural loader driving configuration bytes
`timescale 1ns/1ps
`default_nettype none
module hpt_cfg_loader (
    // Clock
    input wire logic mclk,
    // Configuration port
    output logic [7:0] cfg_addr,
    output logic [7:0] cfg_wdata,
    output logic cfg_wr,
    output logic cfg_rd,
    input wire logic [7:0] cfg_rdata,
    input wire logic cfg_rvalid
);
    initial begin
        cfg_addr = 8'h00;
        cfg_wdata = 8'h00;
        cfg_wr = 1'b0;
        cfg_rd = 1'b0;
    end
    // Released lines flip so a stale value never passes
    task automatic put(input logic [7:0] a, input logic [7:0] d, input logic wr);
        @(posedge mclk);
        cfg_addr <= a;
        cfg_wdata <= d;
        cfg_wr <= wr;
        cfg_rd <= !wr;
        @(posedge mclk);
        cfg_wr <= 1'b0;
        cfg_rd <= 1'b0;
        cfg_addr <= ~a;
        cfg_wdata <= ~d;
    endtask : put
    task automatic get(input logic [7:0] a, output logic [7:0] d, output logic v);
        put(a, 8'h00, 1'b0);
        #1;
        v = cfg_rvalid;
        d = cfg_rdata;
    endtask : get
endmodule : hpt_cfg_loader
`default_nettype wire

// >>> verif/hpt_tuning_regs_monitor.sv
// Concurrent checks on the tuning register ports
`timescale 1ns/1ps
`default_nettype none
module hpt_tuning_regs_monitor (
    // Clock and reset
    input wire logic mclk,
    input wire logic nrst,
    // Configuration port
    input wire logic [7:0] cfg_addr,
    input wire logic [7:0] cfg_wdata,
    input wire logic cfg_wr,
    input wire logic cfg_rd,
    input wire logic [7:0] cfg_rdata,
    input wire logic cfg_rvalid,
    // Controls and pins
    input wire hpt_pkg::hpt_boost_t drive_boost,
    input wire logic [4:0] swap_active,
    input wire hpt_pkg::hpt_pair_drv_t [4:0] xcvr_drv,
    input wire hpt_pkg::hpt_pair_rcv_t [4:0] xcvr_rcv,
    input wire logic [4:0] positive_data_pin_out,
    input wire logic [4:0] positive_data_pin_oe_n,
    input wire logic [4:0] positive_data_pin_in,
    input wire logic [4:0] negative_data_pin_out,
    input wire logic [4:0] negative_data_pin_oe_n,
    input wire logic [4:0] negative_data_pin_in
);
    default clocking @(posedge mclk); endclocking
    default disable iff (!nrst);
    wire wb = cfg_wr && cfg_addr == hpt_pkg::ADDR_DOWNSTREAM_DRIVE_BOOST;
    wire ws = cfg_wr && cfg_addr == hpt_pkg::ADDR_DATA_PIN_SWAP;
    wire rs = cfg_rd && cfg_addr == hpt_pkg::ADDR_DATA_PIN_SWAP;
    wire rm = cfg_rd && !rs && cfg_addr != hpt_pkg::ADDR_DOWNSTREAM_DRIVE_BOOST;
    chk_boost_load: assert property (
        wb ##1 !wb |=> drive_boost == $past(cfg_wdata, 2)) else $error("Boost load wrong");
    chk_boost_hold: assert property (
        !$past(wb, 2) |-> $stable(drive_boost)) else $error("Boost moved unasked");
    chk_swap_load: assert property (
        ws ##1 !ws |=> swap_active == {$past(cfg_wdata[3], 2), 1'b0, $past(cfg_wdata[2:0], 2)})
        else $error("Swap load wrong");
    chk_slot_three: assert property (
        swap_active[3] == 1'b0) else $error("Port three swapped");
    chk_reserved_read: assert property (
        rs |=> cfg_rdata[7:4] == 4'h0) else $error("Reserved swap bits read back");
    chk_unmapped_read: assert property (
        rm |=> cfg_rvalid && cfg_rdata == hpt_pkg::UNMAPPED_READ) else $error("Unmapped read");
    for (genvar g = 0; g < 5; g++) begin : g_slot
        wire [3:0] pv = {positive_data_pin_out[g], positive_data_pin_oe_n[g],
            negative_data_pin_out[g], negative_data_pin_oe_n[g]};
        chk_pins_straight: assert property (
            !swap_active[g] |-> pv == xcvr_drv[g]) else $error("Straight pins wrong");
        chk_pins_crossed: assert property (
            swap_active[g] |-> pv == {xcvr_drv[g][1:0], xcvr_drv[g][3:2]}) else $error("Crossed");
        chk_rcv_path: assert property (
            xcvr_rcv[g] == (swap_active[g] ?
            {$past(negative_data_pin_in[g], 2), $past(positive_data_pin_in[g], 2)} :
            {$past(positive_data_pin_in[g], 2), $past(negative_data_pin_in[g], 2)}))
            else $error("Receive path wrong");
    end
    cover property (wb);
    cover property (ws);
    cover property (cfg_rd ##1 cfg_rvalid);
endmodule : hpt_tuning_regs_monitor
bind hpt_tuning_regs hpt_tuning_regs_monitor mon_u (.mclk, .nrst, .cfg_addr, .cfg_wdata,
    .cfg_wr, .cfg_rd, .cfg_rdata, .cfg_rvalid, .drive_boost, .swap_active, .xcvr_drv,
    .xcvr_rcv, .positive_data_pin_out, .positive_data_pin_oe_n, .positive_data_pin_in,
    .negative_data_pin_out, .negative_data_pin_oe_n, .negative_data_pin_in);
`default_nettype wire

// >>> verif/hub_port_phy_tuning_regs_tb.sv
// Self-checking bench for the tuning registers
`timescale 1ns/1ps
`default_nettype none
module hub_port_phy_tuning_regs_tb;
    logic mclk, nrst, cfg_wr, cfg_rd, cfg_rvalid;
    logic [7:0] cfg_addr, cfg_wdata, cfg_rdata;
    hpt_pkg::hpt_boost_t drive_boost;
    hpt_pkg::hpt_pair_drv_t [4:0] xcvr_drv;
    hpt_pkg::hpt_pair_rcv_t [4:0] xcvr_rcv;
    logic [4:0] swap_active, positive_data_pin_out, positive_data_pin_oe_n, positive_data_pin_in;
    logic [4:0] negative_data_pin_out, negative_data_pin_oe_n, negative_data_pin_in;
    int num_errors, checked;
    hpt_tuning_regs dut_u (.mclk, .nrst, .cfg_addr, .cfg_wdata, .cfg_wr, .cfg_rd, .cfg_rdata,
        .cfg_rvalid, .drive_boost, .swap_active, .xcvr_drv, .xcvr_rcv, .positive_data_pin_out,
        .positive_data_pin_oe_n, .positive_data_pin_in, .negative_data_pin_out,
        .negative_data_pin_oe_n, .negative_data_pin_in);
    hpt_cfg_loader loader_u (.mclk, .cfg_addr, .cfg_wdata, .cfg_wr, .cfg_rd, .cfg_rdata,
        .cfg_rvalid);
    always #2.5 mclk = ~mclk;
    task automatic check(input logic [19:0] seen, input logic [19:0] exp);
        checked++;
        if (seen !== exp) begin
            num_errors++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
        logic [7:0] d;
        logic v;
        loader_u.get(a, d, v);
        check(v, 1'b1);
        check(d, e);
    endtask : rd_chk
    task automatic settle();
        repeat (2) @(posedge mclk);
        #1;
    endtask : settle
    task automatic t_reset();
        rd_chk(hpt_pkg::ADDR_DOWNSTREAM_DRIVE_BOOST, hpt_pkg::RST_DOWNSTREAM_DRIVE_BOOST);
        rd_chk(hpt_pkg::ADDR_DATA_PIN_SWAP, hpt_pkg::RST_DATA_PIN_SWAP);
        check({drive_boost, swap_active}, 13'h0000);
    endtask : t_reset
    task automatic t_boost();
        loader_u.put(8'hf8, 8'he4, 1'b1);
        settle();
        check(drive_boost, {hpt_pkg::HPT_DRIVE_HIGH_BOOST, hpt_pkg::HPT_DRIVE_MEDIUM_BOOST,
            hpt_pkg::HPT_DRIVE_LOW_BOOST, hpt_pkg::HPT_DRIVE_NORMAL});
        loader_u.put(8'hf8, 8'h1b, 1'b1);
        settle();
        check(drive_boost.port_four_drive_level, 2'b00);
        check(drive_boost.port_three_drive_level, 2'b01);
        check(drive_boost.port_two_drive_level, 2'b10);
        check(drive_boost.port_one_drive_level, 2'b11);
        rd_chk(8'hf8, 8'h1b);
    endtask : t_boost
    task automatic t_swap();
        logic [7:0] w;
        for (int i = 0; i < 8; i++) begin
            w = 8'h01 << i;
            loader_u.put(8'hfa, w, 1'b1);
            settle();
            check(swap_active, {w[3], 1'b0, w[2:0]});
            rd_chk(8'hfa, w & 8'h0f);
        end
    endtask : t_swap
    task automatic t_pins();
        logic [7:0] w;
        logic [4:0] sw;
        logic [3:0] d;
        // Neighbouring slots differ in drive and pin levels so a mix-up of adjacent slots shows
        for (int s = 0; s < 3; s++) begin
            w = (s == 0) ? 8'h00 : (s == 1) ? 8'hff : 8'h0a;
            sw = {w[3], 1'b0, w[2:0]};
            loader_u.put(8'hfa, w, 1'b1);
            xcvr_drv <= {4'b1001, 4'b0110, 4'b1001, 4'b0110, 4'b1001};
            positive_data_pin_in <= 5'h15;
            negative_data_pin_in <= 5'h0a;
            repeat (4) @(posedge mclk);
            #1;
            for (int g = 0; g < 5; g++) begin
                d = xcvr_drv[g];
                check({positive_data_pin_out[g], positive_data_pin_oe_n[g],
                    negative_data_pin_out[g], negative_data_pin_oe_n[g]},
                    sw[g] ? {d[1:0], d[3:2]} : d);
                check(xcvr_rcv[g], sw[g] ? {negative_data_pin_in[g], positive_data_pin_in[g]}
                    : {positive_data_pin_in[g], negative_data_pin_in[g]});
            end
        end
    endtask : t_pins
    task automatic t_unmapped();
        loader_u.put(8'hf9, 8'hff, 1'b1);
        loader_u.put(8'hfb, 8'hff, 1'b1);
        rd_chk(8'hf9, hpt_pkg::UNMAPPED_READ);
        rd_chk(8'hfa, 8'h0a);
        rd_chk(8'hf8, 8'h1b);
        loader_u.put(8'hf8, 8'h00, 1'b1);
        rd_chk(8'hf8, 8'h00);
    endtask : t_unmapped
    task automatic conclude();
        $display("Checks %0d, errors %0d", checked, num_errors);
        if (num_errors == 0 && checked > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : conclude
    initial begin
        #20000;
        num_errors++;
        conclude();
    end
    initial begin
        mclk = 1'b0;
        nrst = 1'b0;
        xcvr_drv = '0;
        positive_data_pin_in = 5'h00;
        negative_data_pin_in = 5'h00;
        num_errors = 0;
        checked = 0;
        repeat (6) @(posedge mclk);
        nrst <= 1'b1;
        repeat (3) @(posedge mclk);
        t_reset();
        t_boost();
        t_swap();
        t_pins();
        t_unmapped();
        conclude();
    end
endmodule : hub_port_phy_tuning_regs_tb
`default_nettype wire
